// ---- logic/fmas_autobaud.v ----
// Bit-rate measurement for the serial link used by boot mode.
`timescale 1ns/1ps
module fmas_autobaud #(
    parameter CW = 16
) (
    input wire ref_clk,
    input wire rstn,
    input wire clkEn,
    input wire start,
    input wire rxd,
    output reg [CW-1:0] bitCycles_q,
    output reg locked_q
);
    localparam S_IDLE = 2'h0;
    localparam S_WAITLOW = 2'h1;
    localparam S_COUNT = 2'h2;
    localparam S_DONE = 2'h3;
    reg [1:0] state_q;
    reg [CW-1:0] cnt_q;
    localparam [CW-1:0] SPAN_BITS = {{(CW-4){1'b0}}, 4'h9};
    // The host sends a zero byte; the low start-plus-data span is nine bits.
    always @(posedge ref_clk) begin
        if (!rstn) begin
            state_q <= S_IDLE;
            cnt_q <= {CW{1'b0}};
            bitCycles_q <= {CW{1'b0}};
            locked_q <= 1'b0;
        end else if (clkEn) begin
            case (state_q)
                S_IDLE: begin
                    if (start) begin
                        state_q <= S_WAITLOW;
                        locked_q <= 1'b0;
                    end
                end
                S_WAITLOW: begin
                    cnt_q <= {CW{1'b0}};
                    if (!rxd) begin
                        // The edge that sees the line fall is the first low cycle.
                        cnt_q <= {{(CW-1){1'b0}}, 1'b1};
                        state_q <= S_COUNT;
                    end
                end
                S_COUNT: begin
                    if (rxd) begin
                        bitCycles_q <= cnt_q / SPAN_BITS;
                        state_q <= S_DONE;
                    end else if (cnt_q != {CW{1'b1}}) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_DONE: begin
                    locked_q <= 1'b1;
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- logic/fmas_decode.v ----
// Address decoder that routes a CPU access to one of the flash arrays.
`timescale 1ns/1ps
module fmas_decode (
    input wire [23:0] addr,
    input wire wideMode,
    input wire bootSel,
    output reg hitFlash,
    output reg hitUser,
    output reg hitBoot,
    output reg beyondBoot
);
`include "fmas_regs.vh"
    always @* begin
        // [RULE_01] [RULE_02]
        if (wideMode) begin
            hitFlash = addr <= `FMAS_WIDE_HI;
        end else begin
            hitFlash = addr <= `FMAS_NARROW_HI;
        end
        // [RULE_13] [RULE_14]
        hitUser = hitFlash && !bootSel;
        hitBoot = hitFlash && bootSel;
        // [RULE_15]
        beyondBoot = hitBoot && (addr > `FMAS_BOOT_ARRAY_HI);
    end
endmodule

// ---- logic/fmas_regs.vh ----
// Register offsets, field positions, reset values and mode codes.
`ifndef FMAS_REGS_VH
`define FMAS_REGS_VH
`define FMAS_REG_CTRL 4'h0
`define FMAS_REG_SEL 4'h1
`define FMAS_REG_STAT 4'h2
`define FMAS_REG_OPADDR 4'h3
`define FMAS_REG_OPCMD 4'h4
`define FMAS_REG_AUTOBAUD 4'h5
`define FMAS_CTRL_ENABLE_BIT 0
`define FMAS_SEL_BOOT_BIT 0
`define FMAS_CTRL_RESET 8'h00
`define FMAS_SEL_RESET 8'h00
`define FMAS_MODE_USER 3'h0
`define FMAS_MODE_USERPROG 3'h1
`define FMAS_MODE_USERBOOT 3'h2
`define FMAS_MODE_BOOT 3'h3
`define FMAS_MODE_PROGRAMMER 3'h4
`define FMAS_CMD_NONE 2'h0
`define FMAS_CMD_PROGRAM 2'h1
`define FMAS_CMD_BLOCK_ERASE 2'h2
`define FMAS_CMD_ALL_ERASE 2'h3
`define FMAS_WIDE_LO 24'h000000
`define FMAS_WIDE_HI 24'h07FFFF
`define FMAS_NARROW_LO 24'h000000
`define FMAS_NARROW_HI 24'h00DFFF
`define FMAS_BOOT_ARRAY_HI 24'h001FFF
`define FMAS_PROG_GROUP_BYTES 8'h80
`define FMAS_EMB_VECTOR_CYCLES 4'h4
`endif

// ---- logic/fmas_top.v ----
// Flash mode control, array selection and program or erase gating.
// Function
// (RULE_01) Wide mode decodes 000000 to 07FFFF.
// (RULE_02) Narrow mode decodes 0000 to DFFF.
// (RULE_03) User mode reset selects the user array.
// (RULE_04) User boot reset selects boot array.
// (RULE_05) Programming uses 128-byte groups.
// (RULE_06) User mode reads only, no alteration.
// (RULE_07) Alteration only in three on-board modes.
// (RULE_08) Boot array altered only in boot mode.
// (RULE_09) Boot entry erases all, blocks reads.
// (RULE_10) Block erase follows whole-array erase.
// (RULE_11) User boot vector: embedded first, then array.
// (RULE_12) Leave program mode by clearing enable.
// (RULE_13) Array select register routes accesses.
// (RULE_14) Reads allowed in every mode.
// (RULE_15) Beyond boot array size reads undefined.
// (RULE_16) Boot mode adjusts serial bit rate.
// (RULE_17) User boot accepts its own mode pins.
// (RULE_18) Software sets enable bit for programming.
// (RULE_19) Forbidden program or erase is ignored.
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
module fmas_top #(
    parameter ERASE_CYCLES = 64,
    parameter BAUD_W = 16
) (
    input wire ref_clk,
    input wire rstn,
    input wire clkEn,
    input wire [2:0] modePins,
    input wire wideMode,
    input wire [3:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdata,
    input wire [23:0] cpuAddr,
    input wire cpuRd,
    output wire selUser,
    output wire selBoot,
    output wire readOk,
    output wire readUndef,
    output reg [1:0] flashCmd,
    output reg flashCmdBoot,
    output reg [23:0] flashAddr,
    output reg flashCmdValid,
    input wire flashBusy,
    output reg vecFromEmbedded,
    input wire serialRxd,
    output wire [BAUD_W-1:0] baudCycles
);
`include "fmas_regs.vh"
    localparam ST_RESET = 2'h0;
    localparam ST_ERASE = 2'h1;
    localparam ST_VECTOR = 2'h2;
    localparam ST_RUN = 2'h3;

    reg [2:0] mode_q;
    reg [1:0] state_q;
    reg ctrlEnable_q;
    reg arraySel_q;
    reg allErased_q;
    reg refused_q;
    reg [23:0] opAddr_q;
    reg [15:0] timer_q;
    reg [3:0] vecCnt_q;
    reg baudStart_q;
    wire hitFlash;
    wire hitUser;
    wire hitBoot;
    wire beyondBoot;
    wire baudLocked;
    reg [2:0] effMode;
    reg cmdAllowed;

    // Alteration rights depend on the effective mode and target array.
    function allowed;
        input [2:0] md;
        input toBoot;
        begin
            case (md)
                `FMAS_MODE_BOOT: allowed = 1'b1; // [RULE_07] [RULE_08]
                `FMAS_MODE_USERPROG: allowed = !toBoot; // [RULE_08]
                `FMAS_MODE_USERBOOT: allowed = !toBoot; // [RULE_08]
                default: allowed = 1'b0; // [RULE_06]
            endcase
        end
    endfunction

    fmas_decode u_dec (
        .addr(cpuAddr),
        .wideMode(wideMode),
        .bootSel(arraySel_q),
        .hitFlash(hitFlash),
        .hitUser(hitUser),
        .hitBoot(hitBoot),
        .beyondBoot(beyondBoot)
    );

    fmas_autobaud #(.CW(BAUD_W)) u_baud (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .start(baudStart_q),
        .rxd(serialRxd),
        .bitCycles_q(baudCycles),
        .locked_q(baudLocked)
    );

    always @* begin
        // The enable bit turns plain user mode into user program mode.
        if (mode_q == `FMAS_MODE_USER && ctrlEnable_q) begin
            effMode = `FMAS_MODE_USERPROG; // [RULE_12] [RULE_18]
        end else begin
            effMode = mode_q;
        end
        cmdAllowed = allowed(effMode, arraySel_q) && state_q == ST_RUN;
    end

    assign selUser = hitUser;
    assign selBoot = hitBoot;
    // Reads stay blocked in boot mode until the whole erase has finished.
    assign readOk = cpuRd && hitFlash && state_q == ST_RUN &&
        (mode_q != `FMAS_MODE_BOOT || allErased_q); // [RULE_09] [RULE_14]
    assign readUndef = cpuRd && beyondBoot; // [RULE_15]

    always @(posedge ref_clk) begin
        if (!rstn) begin
            mode_q <= `FMAS_MODE_USER;
            state_q <= ST_RESET;
            ctrlEnable_q <= 1'b0;
            arraySel_q <= 1'b0;
            allErased_q <= 1'b0;
            refused_q <= 1'b0;
            opAddr_q <= 24'h000000;
            timer_q <= 16'h0000;
            vecCnt_q <= 4'h0;
            baudStart_q <= 1'b0;
            flashCmd <= `FMAS_CMD_NONE;
            flashCmdBoot <= 1'b0;
            flashAddr <= 24'h000000;
            flashCmdValid <= 1'b0;
            vecFromEmbedded <= 1'b0;
        end else if (clkEn) begin
            flashCmdValid <= 1'b0;
            baudStart_q <= 1'b0;
            case (state_q)
                ST_RESET: begin
                    // Mode pins are caught once, after reset release.
                    mode_q <= modePins; // [RULE_17]
                    arraySel_q <= modePins == `FMAS_MODE_USERBOOT; // [RULE_03] [RULE_04]
                    if (modePins == `FMAS_MODE_BOOT) begin
                        state_q <= ST_ERASE;
                        timer_q <= 16'h0000;
                        flashCmd <= `FMAS_CMD_ALL_ERASE; // [RULE_09]
                        flashCmdValid <= 1'b1;
                        baudStart_q <= 1'b1; // [RULE_16]
                    end else if (modePins == `FMAS_MODE_USERBOOT) begin
                        state_q <= ST_VECTOR;
                        vecFromEmbedded <= 1'b1; // [RULE_11]
                        vecCnt_q <= 4'h0;
                    end else begin
                        state_q <= ST_RUN;
                    end
                end
                ST_ERASE: begin
                    if (timer_q >= ERASE_CYCLES[15:0] && !flashBusy) begin
                        allErased_q <= 1'b1; // [RULE_09] [RULE_10]
                        state_q <= ST_RUN;
                    end else begin
                        timer_q <= timer_q + 16'h0001;
                    end
                end
                ST_VECTOR: begin
                    if (vecCnt_q == `FMAS_EMB_VECTOR_CYCLES) begin
                        vecFromEmbedded <= 1'b0; // [RULE_11]
                        state_q <= ST_RUN;
                    end else begin
                        vecCnt_q <= vecCnt_q + 4'h1;
                    end
                end
                ST_RUN: begin
                end
                default: begin
                    state_q <= ST_RESET;
                end
            endcase
            if (regWr) begin
                case (regAddr)
                    `FMAS_REG_CTRL: ctrlEnable_q <=
                        regWdata[`FMAS_CTRL_ENABLE_BIT]; // [RULE_12]
                    `FMAS_REG_SEL: arraySel_q <=
                        regWdata[`FMAS_SEL_BOOT_BIT]; // [RULE_13]
                    `FMAS_REG_OPADDR: opAddr_q <= {regWdata, opAddr_q[23:8]};
                    `FMAS_REG_OPCMD: begin
                        // Forbidden requests leave the flash untouched.
                        if (cmdAllowed && regWdata[1:0] != `FMAS_CMD_NONE) begin
                            flashCmd <= regWdata[1:0];
                            flashCmdBoot <= arraySel_q;
                            flashCmdValid <= 1'b1;
                            refused_q <= 1'b0;
                            if (regWdata[1:0] == `FMAS_CMD_PROGRAM) begin
                                // Program address aligns to the group.
                                flashAddr <= {opAddr_q[23:7], 7'h00}; // [RULE_05]
                            end else begin
                                flashAddr <= opAddr_q;
                            end
                        end else begin
                            refused_q <= 1'b1; // [RULE_06] [RULE_19]
                        end
                    end
                    `FMAS_REG_AUTOBAUD: baudStart_q <=
                        mode_q == `FMAS_MODE_BOOT; // [RULE_16]
                    default: begin
                    end
                endcase
            end
        end
    end

    always @(posedge ref_clk) begin
        if (!rstn) begin
            regRdata <= 8'h00;
        end else if (clkEn) begin
            if (regRd) begin
                case (regAddr)
                    `FMAS_REG_CTRL: regRdata <= {7'h00, ctrlEnable_q};
                    `FMAS_REG_SEL: regRdata <= {7'h00, arraySel_q};
                    `FMAS_REG_STAT: regRdata <= {baudLocked, refused_q,
                        allErased_q, flashBusy, state_q, effMode[1:0]};
                    `FMAS_REG_OPADDR: regRdata <= opAddr_q[23:16];
                    default: regRdata <= 8'h00;
                endcase
            end else begin
                regRdata <= 8'h00;
            end
        end
    end
endmodule

// ---- tb/fmas_flash_model.sv ----
// Far side: flash array busy response and the boot host serial line.
`timescale 1ns/1ps
module fmas_flash_model #(
    parameter BUSY_CYCLES = 3,
    parameter BIT_CYCLES = 10
) (
    input wire ref_clk,
    input wire flashCmdValid,
    input wire sendZero,
    output wire flashBusy,
    output wire serialRxd
);
    int busyCnt = 0;
    int bitCnt = 0;
    always @(posedge ref_clk) begin
        busyCnt <= flashCmdValid ? BUSY_CYCLES : busyCnt - (busyCnt > 0);
        bitCnt <= sendZero ? 9 * BIT_CYCLES : bitCnt - (bitCnt > 0);
    end
    assign flashBusy = busyCnt > 0;
    // A zero byte keeps the line low for start plus eight data bits.
    assign serialRxd = !(bitCnt > 0);
endmodule

// ---- tb/fmas_props.sv ----
// Port assertions for the flash mode and array select block.
`timescale 1ns/1ps
module fmas_props #(
    parameter ERASE_CYCLES = 64
) (
    input wire ref_clk,
    input wire rstn,
    input wire clkEn,
    input wire regWr,
    input wire [3:0] regAddr,
    input wire [7:0] regWdata,
    input wire [2:0] modePins,
    input wire wideMode,
    input wire [23:0] cpuAddr,
    input wire selUser,
    input wire selBoot,
    input wire readOk,
    input wire readUndef,
    input wire [1:0] flashCmd,
    input wire flashCmdBoot,
    input wire [23:0] flashAddr,
    input wire flashCmdValid,
    input wire vecFromEmbedded
);
    // The mode is copied at the first edge out of reset, as the block does.
    logic rstnPrev = 1'b0;
    logic [2:0] modeQ = 3'h0;
    int cnt = 0;
    // The enable bit turns plain user mode into user program mode.
    logic ctrlEn = 1'b0;
    always @(posedge ref_clk) begin
        rstnPrev <= rstn;
        if (!rstn)
            ctrlEn <= 1'b0;
        else if (clkEn && regWr && regAddr == 4'h0)
            ctrlEn <= regWdata[0];
        cnt <= rstn ? cnt + 1 : 0;
        if (rstn && !rstnPrev)
            modeQ <= modePins;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_sel_onehot: assert property (!(selUser && selBoot))
        else $error("both arrays hit");
    a_wide_range: assert property (wideMode && cpuAddr > 24'h07FFFF
        |-> !selUser && !selBoot) else $error("wide overrun");
    a_narrow_range: assert property (!wideMode && cpuAddr > 24'h00DFFF
        |-> !selUser && !selBoot) else $error("narrow overrun");
    a_undef_span: assert property (readUndef |-> cpuAddr > 24'h001FFF)
        else $error("undefined inside array");
    a_prog_group: assert property (flashCmdValid && flashCmd == 2'h1
        |-> flashAddr[6:0] == 7'h00) else $error("group misaligned");
    a_user_locked: assert property (cnt > 0 && (modeQ == 3'h4 ||
        (modeQ == 3'h0 && !ctrlEn)) |-> !flashCmdValid)
        else $error("alteration in locked mode");
    a_boot_array: assert property (flashCmdValid && flashCmdBoot
        && flashCmd != 2'h3 |-> modeQ == 3'h3) else $error("boot array altered");
    a_boot_blocked: assert property (cnt > 0 && cnt < ERASE_CYCLES
        && modeQ == 3'h3 |-> !readOk) else $error("read before erase");
    a_vec_mode: assert property (vecFromEmbedded |-> modeQ == 3'h2)
        else $error("embedded vector outside user boot");
    a_vec_length: assert property ($fell(vecFromEmbedded)
        |-> $past(vecFromEmbedded, 5)) else $error("embedded vector too short");
    c_boot_cmd: cover property (flashCmdValid && flashCmdBoot);
    c_undef: cover property (readUndef);
    c_vec: cover property ($fell(vecFromEmbedded));
endmodule
bind fmas_top fmas_props #(.ERASE_CYCLES(ERASE_CYCLES)) fmas_props_inst (
    .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .regWr(regWr),
    .regAddr(regAddr), .regWdata(regWdata), .modePins(modePins),
    .wideMode(wideMode), .cpuAddr(cpuAddr), .selUser(selUser),
    .selBoot(selBoot), .readOk(readOk), .readUndef(readUndef),
    .flashCmd(flashCmd), .flashCmdBoot(flashCmdBoot),
    .flashAddr(flashAddr), .flashCmdValid(flashCmdValid),
    .vecFromEmbedded(vecFromEmbedded)
);

// ---- tb/testbench.sv ----
// Self-checking bench for the flash mode and array select block.
`timescale 1ns/1ps
module testbench;
    logic ref_clk, rstn, wideMode, regWr, regRd, cpuRd, sendZero, rdPend;
    logic clkEn, w, h;
    logic flashCmdValid, flashCmdBoot, flashBusy, vecFromEmbedded, serialRxd;
    logic selUser, selBoot, readOk, readUndef;
    logic [2:0] modePins;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata;
    logic [23:0] cpuAddr, flashAddr, a;
    logic [1:0] flashCmd;
    logic [15:0] baudCycles;
    logic [26:0] e;
    logic [7:0] rdQ[$];
    logic [26:0] cmdQ[$];
    logic [23:0] edges[6] = '{24'h07FFFF, 24'h080000, 24'h00DFFF,
        24'h00E000, 24'h001FFF, 24'h002000};
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    fmas_top #(.ERASE_CYCLES(4)) fmas_top_inst (.ref_clk(ref_clk),
        .rstn(rstn), .clkEn(clkEn), .modePins(modePins), .wideMode(wideMode),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .cpuAddr(cpuAddr), .cpuRd(cpuRd),
        .selUser(selUser), .selBoot(selBoot), .readOk(readOk),
        .readUndef(readUndef), .flashCmd(flashCmd),
        .flashCmdBoot(flashCmdBoot), .flashAddr(flashAddr),
        .flashCmdValid(flashCmdValid), .flashBusy(flashBusy),
        .vecFromEmbedded(vecFromEmbedded), .serialRxd(serialRxd),
        .baudCycles(baudCycles));
    fmas_flash_model fmas_flash_model_inst (.ref_clk(ref_clk),
        .flashCmdValid(flashCmdValid), .sendZero(sendZero),
        .flashBusy(flashBusy), .serialRxd(serialRxd));
    always #4 ref_clk = !ref_clk;
    task automatic check(string what, logic [26:0] seen, logic [26:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Strobes drop for one cycle between accesses so no signal is set twice.
    task automatic acc(logic wrNotRd, logic [3:0] ad, logic [7:0] d);
        if (!wrNotRd)
            rdQ.push_back(d);
        regAddr <= ad;
        regWdata <= d;
        regWr <= wrNotRd;
        regRd <= !wrNotRd;
        @(posedge ref_clk);
        {regWr, regRd} <= 2'h0;
        @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        rdPend <= regRd;
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_fail++;
            complete_run();
        end
        if (rdPend)
            check("regRdata", regRdata, rdQ.pop_front());
        if (flashCmdValid) begin
            e = cmdQ.size() ? cmdQ.pop_front() : 27'h0;
            check("flashCmd", flashCmd, e[25:24]);
            if (e[25:24] == 2'h1)
                check("flashAddr", flashAddr, e[23:0]);
            if (e[25:24] != 2'h3)
                check("flashCmdBoot", flashCmdBoot, e[26]);
        end
    end
    initial begin
        {ref_clk, rstn, wideMode, regWr, regRd, cpuRd, sendZero, rdPend} = 0;
        {modePins, regAddr, regWdata, cpuAddr} = 39'h0;
        clkEn = 1'b1;
        void'($urandom(32'hD279291D));
        for (int m = 0; m < 5; m++) begin
            modePins <= m[2:0];
            wideMode <= 1'b1;
            rstn <= 1'b0;
            repeat (16) @(posedge ref_clk);
            if (m == 3)
                cmdQ.push_back({3'h3, 24'h000000});
            rstn <= 1'b1;
            repeat (2) @(posedge ref_clk);
            check("vecFromEmbedded", vecFromEmbedded, m == 2);
            repeat (12) @(posedge ref_clk);
            acc(1'b0, 4'h1, {7'h00, m == 2});
            acc(1'b0, 4'hF, 8'h00);
            if (m == 0) begin
                acc(1'b1, 4'h4, 8'h01);
                acc(1'b0, 4'h2, 8'h4C);
            end
            // A write while the clock enable is low must not land.
            clkEn <= 1'b0;
            acc(1'b1, 4'h1, 8'h01);
            clkEn <= 1'b1;
            acc(1'b0, 4'h1, {7'h00, m == 2});
            acc(1'b1, 4'h0, 8'h01);
            acc(1'b0, 4'h0, 8'h01);
            for (int s = 0; s < 2; s++) begin
                acc(1'b1, 4'h1, s[7:0]);
                cpuAddr <= 24'h000100;
                cpuRd <= 1'b1;
                @(posedge ref_clk);
                check("sel", {selBoot, selUser, readOk}, {s[0], !s[0], 1'b1});
                for (int c = 1; c < 4; c++) begin
                    a = 24'($urandom) & 24'h07FFFF;
                    for (int b = 0; b < 3; b++)
                        acc(1'b1, 4'h3, 8'(a >> (8 * b)));
                    if (m < 4 && (s == 0 || m == 3))
                        cmdQ.push_back({s[0], c[1:0], a & 24'h07FF80});
                    acc(1'b1, 4'h4, c[7:0]);
                    repeat (6) @(posedge ref_clk);
                end
            end
            if (m == 3) begin
                acc(1'b1, 4'h5, 8'h01);
                sendZero <= 1'b1;
                @(posedge ref_clk);
                sendZero <= 1'b0;
                repeat (100) @(posedge ref_clk);
                check("baudCycles", baudCycles, 16'h000A);
            end
            repeat (40) begin
                a = edges[$urandom_range(5)];
                w = 1'($urandom);
                cpuAddr <= a;
                wideMode <= w;
                @(posedge ref_clk);
                h = a <= (w ? 24'h07FFFF : 24'h00DFFF);
                check("hit", selUser | selBoot, h);
                check("undef", readUndef, h && a > 24'h001FFF);
            end
        end
        check("cmdQ", cmdQ.size(), 27'h0);
        complete_run();
    end
endmodule
